// ---- verilog/serial_shift_output_port.sv ----
// Output stage of one real-time core: direct outputs or ping-pong shift-out.
// Assumes an AXI4-Lite master on aclk; pins go to an external serial receiver.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.

// Functional notes
// - Direct mode: output register drives all routed pins
// - Output register has no reset value
// - Shift mode: data on pin 0, clock pin 1
// - Shift clock from two cascaded half-step dividers
// - Divider field equals twice divisor minus two
// - Shift clock generator always runs internally
// - Clock pin driven only in shift mode
// - Two 16-bit shadow buffers used ping-pong
// - Bits 29/30 load buffers while set
// - Bit 31 starts shifting from buffer a
// - Without reload, old contents keep repeating
// - Clearing bit 31 finishes buffer, then idles
// - Routed pins 2..15 show written value
// - Flag 1 frees buffer a, 0 frees b
// - Direct mode default; one mode at once
module serial_shift_output_port
    import shift_port_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      gpo_pins,
    output logic [31:0]      pin_route_sel
);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0]   out_q;
    cfg_s          cfg_q;
    logic [31:0]   route_q;
    logic [15:0]   buf_a_q;
    logic [15:0]   buf_b_q;
    eng_state_e    state_q;
    logic [3:0]    bit_q;
    logic          cur_q;
    logic          data_q;
    logic          sclk_q;
    logic [6:0]    acc0_q;
    logic [6:0]    acc1_q;
    logic          tick0_q;
    logic          aw_full_q;
    logic          w_full_q;
    logic [3:0]    aw_addr_q;
    logic [31:0]   w_data_q;
    logic [3:0]    w_strb_q;
    logic          wr_fire;
    logic          fall;
    logic          enable;
    logic [6:0]    lim0;
    logic [6:0]    lim1;
    logic [6:0]    sum0;
    logic [6:0]    sum1;
    logic [31:0]   pins_d;
    logic [15:0]   act_buf;

    // Write channel: address and data taken in either order
    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q     <= 1'b0;
            aw_addr_q     <= 4'h0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full_q && !s_axi_awready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_full_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q == ADDR_OUT || aw_addr_q == ADDR_CFG
                             || aw_addr_q == ADDR_ROUTE) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // No reset: firmware must write it before routing pins to the core
    always_ff @(posedge aclk) begin
        if (wr_fire && aw_addr_q == ADDR_OUT) begin
            out_q <= merge(out_q, w_data_q, w_strb_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= '{div_second: DIV_RST, div_first: DIV_RST, shift_mode: 1'b0};
        end else if (wr_fire && aw_addr_q == ADDR_CFG) begin
            if (w_strb_q[0]) begin
                cfg_q.shift_mode <= w_data_q[CFG_MODE_BIT];
            end
            if (w_strb_q[1]) begin
                cfg_q.div_first <= w_data_q[CFG_DIV0_LSB +: DIV_W];
            end
            if (w_strb_q[2]) begin
                cfg_q.div_second <= w_data_q[CFG_DIV1_LSB +: DIV_W];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_q <= ROUTE_RST;
        end else if (wr_fire && aw_addr_q == ADDR_ROUTE) begin
            route_q <= merge(route_q, w_data_q, w_strb_q);
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= 32'h0000_0000;
                case (s_axi_araddr)
                    ADDR_OUT: begin
                        s_axi_rdata <= out_q;
                    end
                    ADDR_CFG: begin
                        s_axi_rdata[CFG_MODE_BIT]              <= cfg_q.shift_mode;
                        s_axi_rdata[CFG_FLAG_BIT]              <= cur_q;
                        s_axi_rdata[CFG_BUSY_BIT]              <= (state_q == ENG_RUN);
                        s_axi_rdata[CFG_DIV0_LSB +: DIV_W]     <= cfg_q.div_first;
                        s_axi_rdata[CFG_DIV1_LSB +: DIV_W]     <= cfg_q.div_second;
                    end
                    ADDR_ROUTE: begin
                        s_axi_rdata <= route_q;
                    end
                    default: begin
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Shift clock: two fractional accumulators counted in half-divisor units.
    // Toggle rate is 2/(d0*d1) per aclk, with d0 saturating at 2 (at most one first-stage tick per aclk).
    assign lim0 = {2'b00, cfg_q.div_first} + DIV_BASE;
    assign lim1 = {2'b00, cfg_q.div_second} + DIV_BASE;
    assign sum0 = acc0_q + DIV0_STEP;
    assign sum1 = acc1_q + DIV1_STEP;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc0_q  <= 7'h00;
            tick0_q <= 1'b0;
        end else if (sum0 >= lim0) begin
            acc0_q  <= (sum0 - lim0 >= lim0) ? 7'h00 : sum0 - lim0;
            tick0_q <= 1'b1;
        end else begin
            acc0_q  <= sum0;
            tick0_q <= 1'b0;
        end
    end

    // Runs regardless of mode or enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc1_q <= 7'h00;
            sclk_q <= 1'b0;
        end else if (tick0_q) begin
            if (sum1 >= lim1) begin
                acc1_q <= sum1 - lim1;
                sclk_q <= !sclk_q;
            end else begin
                acc1_q <= sum1;
            end
        end
    end

    assign fall = tick0_q && (sum1 >= lim1) && sclk_q;

    // Shadow buffers follow the low half while their strobe is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_a_q <= SHADOW_RST;
            buf_b_q <= SHADOW_RST;
        end else begin
            if (out_q[OUT_LOAD_A_BIT]) begin
                buf_a_q <= out_q[SHADOW_W-1:0];
            end
            if (out_q[OUT_LOAD_B_BIT]) begin
                buf_b_q <= out_q[SHADOW_W-1:0];
            end
        end
    end

    assign enable  = out_q[OUT_ENABLE_BIT] && cfg_q.shift_mode;
    assign act_buf = cur_q ? buf_b_q : buf_a_q;

    // Shift engine; data only moves while the clock falls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ENG_IDLE;
            bit_q   <= 4'h0;
            cur_q   <= 1'b0;
            data_q  <= 1'b0;
        end else if (fall) begin
            case (state_q)
                ENG_IDLE: begin
                    if (enable) begin
                        state_q <= ENG_RUN;
                        bit_q   <= 4'h0;
                        cur_q   <= 1'b0;
                        data_q  <= buf_a_q[0];
                    end
                end
                ENG_RUN: begin
                    if (bit_q != 4'hF) begin
                        bit_q  <= bit_q + 4'h1;
                        data_q <= act_buf[bit_q + 4'h1];
                    end else if (enable) begin
                        bit_q  <= 4'h0;
                        cur_q  <= !cur_q;
                        data_q <= cur_q ? buf_a_q[0] : buf_b_q[0];
                    end else begin
                        state_q <= ENG_IDLE;
                        bit_q   <= 4'h0;
                        cur_q   <= 1'b0;
                        data_q  <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ENG_IDLE;
                end
            endcase
        end
    end

    // Pin mapping; unrouted pins are forced low
    always_comb begin
        pins_d = out_q;
        if (cfg_q.shift_mode) begin
            pins_d[PIN_DATA] = data_q;
            pins_d[PIN_CLK]  = sclk_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gpo_pins      <= 32'h0000_0000;
            pin_route_sel <= ROUTE_RST;
        end else begin
            gpo_pins      <= pins_d & route_q;
            pin_route_sel <= route_q;
        end
    end

endmodule

// ---- verilog/shift_port_pkg.sv ----
// Constants and types for the serial shift output port.
// Assumes a single 50 MHz interface clock and an AXI4-Lite register master.
package shift_port_pkg;

    // Register byte addresses
    localparam logic [3:0] ADDR_OUT   = 4'h0;
    localparam logic [3:0] ADDR_CFG   = 4'h4;
    localparam logic [3:0] ADDR_ROUTE = 4'h8;

    // Pin configuration register fields
    localparam int CFG_MODE_BIT = 0;
    localparam int CFG_FLAG_BIT = 1;
    localparam int CFG_BUSY_BIT = 2;
    localparam int CFG_DIV0_LSB = 8;
    localparam int CFG_DIV1_LSB = 16;
    localparam int DIV_W        = 5;

    // Core output register fields
    localparam int OUT_LOAD_A_BIT = 29;
    localparam int OUT_LOAD_B_BIT = 30;
    localparam int OUT_ENABLE_BIT = 31;
    localparam int PIN_DATA       = 0;
    localparam int PIN_CLK        = 1;
    localparam int SHADOW_W       = 16;

    // Reset values
    localparam logic [DIV_W-1:0] DIV_RST     = 5'h00;
    localparam logic [31:0]      ROUTE_RST   = 32'h0000_0000;
    localparam logic [15:0]      SHADOW_RST  = 16'h0000;

    // Divider steps in half-divisor units
    localparam logic [6:0] DIV0_STEP = 7'h04;
    localparam logic [6:0] DIV1_STEP = 7'h02;
    localparam logic [6:0] DIV_BASE  = 7'h02;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} eng_state_e;

    typedef struct packed {
        logic [DIV_W-1:0] div_second;
        logic [DIV_W-1:0] div_first;
        logic             shift_mode;
    } cfg_s;

endpackage

// ---- testbench/serial_shift_output_port_assertions.sv ----
// Port-level assertions for the serial shift output port.
// Assumes it is bound to the top module; one clock, active-low reset.
module serial_shift_output_port_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] gpo_pins,
    input wire logic [31:0] pin_route_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_read_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_rise_clk; $rose(gpo_pins[1]); endsequence
    property p_mask; (gpo_pins & ~pin_route_sel) == 32'h0000_0000; endproperty
    property p_quiet; $rose(aresetn) |-> gpo_pins == 32'h0 && pin_route_sel == 32'h0; endproperty
    property p_edge; s_rise_clk |-> $stable(gpo_pins[0]); endproperty
    property p_rlat; s_read_taken |=> s_axi_rvalid; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_awblk; s_axi_bvalid |-> !s_axi_awready; endproperty
    property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_mask: assert property (p_mask) else $error("Unrouted pin driven");
    a_quiet: assert property (p_quiet) else $error("Pins not quiet after reset");
    a_edge: assert property (p_edge) else $error("Data moved on clock rise");
    a_rlat: assert property (p_rlat) else $error("Read answer late");
    a_rhold: assert property (p_rhold) else $error("Read data dropped");
    a_bhold: assert property (p_bhold) else $error("Write response dropped");
    a_awblk: assert property (p_awblk) else $error("Address taken with response due");
    a_arblk: assert property (p_arblk) else $error("Read taken with data due");
endmodule

bind serial_shift_output_port serial_shift_output_port_assertions serial_shift_output_port_assertions_i (
    .aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .gpo_pins, .pin_route_sel);

// ---- testbench/serial_receiver_model.sv ----
// Behavioural serial receiver on the data and clock pins.
// Assumes pins are seen on aclk and the shift clock is at most aclk/2.
module serial_receiver_model (
    input  wire logic        aclk,
    input  wire logic        clk_pin,
    input  wire logic        data_pin,
    input  wire logic        arm,
    output logic [15:0]      word_q,
    output int               words_q,
    output int               period_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_prev;
    logic        run;
    logic [15:0] sh;
    int          bits;
    int          gap;
    initial begin
        {clk_prev, run, sh, bits, gap} = '0;
        {word_q, words_q, period_q} = '0;
    end
    // Syncs on the first set bit, so the first word must start with a 1
    always @(posedge aclk) begin
        gap = gap + 1;
        if (clk_pin && !clk_prev) begin
            period_q <= gap;
            gap = 0;
            if (!arm) begin
                run = 1'b0;
                bits = 0;
            end else if (run || data_pin) begin
                run = 1'b1;
                sh = {data_pin, sh[15:1]};
                bits = bits + 1;
                if (bits == 16) begin
                    bits = 0;
                    word_q <= sh;
                    words_q <= words_q + 1;
                end
            end
        end
        clk_prev = clk_pin;
    end
endmodule

// ---- testbench/serial_shift_output_port_test.sv ----
// Self-checking bench: AXI4-Lite register tasks, direct and shift-out tests.
// Assumes the design, checker and receiver model are compiled first.
module serial_shift_output_port_test import shift_port_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, arm, seen;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata, s_axi_rdata, gpo_pins, pin_route_sel;
    logic [15:0] word_q;
    int          words_q, period_q, err_total, checks_done, cycles;
    localparam logic [4:0] DIV0_TAB [3] = '{5'h1E, 5'h12, 5'h02};
    localparam logic [4:0] DIV1_TAB [3] = '{5'h00, 5'h02, 5'h02};
    localparam int         PER_TAB  [3] = '{16, 20, 4};

    serial_shift_output_port serial_shift_output_port_i (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .gpo_pins, .pin_route_sel);
    serial_receiver_model serial_receiver_model_i (.aclk, .clk_pin(gpo_pins[PIN_CLK]),
        .data_pin(gpo_pins[PIN_DATA]), .arm, .word_q, .words_q, .period_q);

    always #10 aclk = ~aclk;

    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checks_done++;
        if (seen_v !== exp_v) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Runs out of a hung handshake or a silent shift engine
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, r});
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, d);
        check({30'h0, s_axi_rresp}, {30'h0, r});
    endtask

    task automatic wait_word(input int n, input logic [15:0] w);
        while (words_q < n) @(posedge aclk);
        check({16'h0, word_q}, {16'h0, w});
    endtask

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, arm, err_total, checks_done, cycles} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        check(gpo_pins, 32'h0);
        axi_rd(ADDR_CFG, 32'h0, RESP_OKAY);
        axi_wr(4'hC, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_rd(ADDR_ROUTE, ROUTE_RST, RESP_OKAY);
        axi_rd(4'hC, 32'h0, RESP_SLVERR);
        // Top three bits clear, so no strobe or enable is left over for the shift tests
        axi_wr(ADDR_OUT, 32'h15A5_5A5A);
        axi_wr(ADDR_ROUTE, 32'hFFFF_FFFF);
        repeat (2) @(posedge aclk);
        check(gpo_pins, 32'h15A5_5A5A);
        axi_wr(ADDR_ROUTE, 32'h0000_FF00);
        repeat (2) @(posedge aclk);
        check(gpo_pins, 32'h0000_5A00);
        check(pin_route_sel, 32'h0000_FF00);
        axi_wr(ADDR_ROUTE, 32'hFFFF_FFFF);
        $display("test direct done");
        for (int i = 0; i < 3; i++) begin
            axi_wr(ADDR_CFG, {11'h0, DIV1_TAB[i], 3'h0, DIV0_TAB[i], 8'h01});
            repeat (60) @(posedge aclk);
            check(period_q, PER_TAB[i]);
        end
        $display("test divider done");
        axi_wr(ADDR_OUT, 32'h2000_C3A5);
        axi_wr(ADDR_OUT, 32'h0000_C3A5);
        axi_wr(ADDR_OUT, 32'h4000_5A0F);
        axi_wr(ADDR_OUT, 32'h0000_5A0F);
        arm <= 1'b1;
        axi_wr(ADDR_OUT, 32'h8000_5A0F);
        wait_word(1, 16'hC3A5);
        axi_rd(ADDR_CFG, 32'h0002_0207, RESP_OKAY);
        axi_wr(ADDR_OUT, 32'hA000_9E37);
        axi_wr(ADDR_OUT, 32'h8000_9E37);
        check({18'h0, gpo_pins[15:2]}, {18'h0, 14'h278D});
        wait_word(2, 16'h5A0F);
        wait_word(3, 16'h9E37);
        axi_wr(ADDR_OUT, 32'h0000_9E37);
        wait_word(4, 16'h5A0F);
        wait_word(5, 16'h0000);
        axi_rd(ADDR_CFG, 32'h0002_0201, RESP_OKAY);
        $display("test shift done");
        axi_wr(ADDR_OUT, 32'h0000_0000);
        axi_wr(ADDR_CFG, 32'h0002_0200);
        seen = 1'b0;
        repeat (20) begin
            @(posedge aclk);
            seen = seen | gpo_pins[PIN_CLK];
        end
        check({31'h0, seen}, 32'h0);
        $display("test clock pin done");
        give_verdict();
    end
endmodule
